//--- dpl_pkg.sv
// shared constants for the digipot serial latch controller
package dpl_pkg;
    localparam int unsigned DPL_CODE_W = 8;
    localparam logic [7:0] DPL_MIDSCALE = 8'h80;
    localparam logic DPL_PIN_IDLE_LO = 1'b0;
    localparam logic DPL_PIN_IDLE_HI = 1'b1;
    localparam int unsigned DPL_CHAIN_TAP = 8;
    localparam int unsigned DPL_MCLK_NS = 100;
    localparam int unsigned DPL_LINK_NS = 800;
endpackage : dpl_pkg

//--- dpl_sync2.sv
// two-flop synchroniser for one pin input
`timescale 1ns/100ps
module dpl_sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // level in and out
    input wire logic async_i,
    output logic sync_o
);
    typedef struct packed {
        logic meta;
        logic sync;
    } dpl_sync_t;

    dpl_sync_t st_q, st_d;

    always_comb begin
        st_d.meta = async_i;
        st_d.sync = st_q.meta;
    end

    // reset to the pin's idle level, else an edge detector sees a false edge
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= '{meta: RST_VAL, sync: RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.sync;
endmodule : dpl_sync2

//--- dpl_serial_latch.sv
// serial shift register and wiper code latches of the digipot
`timescale 1ns/100ps
module dpl_serial_latch
    import dpl_pkg::*;
#(
    parameter int unsigned CHANNELS = 2
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // serial link pins
    input wire logic link_clk_i,
    input wire logic chip_sel_n_i,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe_o,
    // control pins
    input wire logic midscale_force_n_i,
    input wire logic power_down_n_i,
    // analog switch controls and latch contents
    output logic [7:0] wiper_code_latch1_o,
    output logic [7:0] wiper_code_latch2_o,
    output logic high_end_open_o,
    output logic wiper_to_low_o
);
    localparam int unsigned WORD_W =
        (CHANNELS > 1) ? DPL_CODE_W + 1 : DPL_CODE_W;

    typedef struct packed {
        logic clk_prev;
        logic cs_prev;
        logic pr_prev;
        logic [WORD_W-1:0] shift_register;
        logic sdo_bit;
        logic [DPL_CODE_W-1:0] lat1;
        logic [DPL_CODE_W-1:0] lat2;
    } dpl_state_t;

    dpl_state_t st_q, st_d;
    logic clk_s, cs_n_s, sdi_s, pr_n_s, pd_n_s;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    // clock and data pass the same depth, so they stay aligned; the price
    // is two cycles of latency and a preset that is not truly asynchronous
    dpl_sync2 #(
        .RST_VAL(DPL_PIN_IDLE_LO)
    ) u_sync_clk (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(link_clk_i),
        .sync_o(clk_s)
    );
    dpl_sync2 #(
        .RST_VAL(DPL_PIN_IDLE_HI)
    ) u_sync_cs (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(chip_sel_n_i),
        .sync_o(cs_n_s)
    );
    dpl_sync2 #(
        .RST_VAL(DPL_PIN_IDLE_LO)
    ) u_sync_sdi (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(serial_in_pin_i),
        .sync_o(sdi_s)
    );
    dpl_sync2 #(
        .RST_VAL(DPL_PIN_IDLE_HI)
    ) u_sync_pr (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(midscale_force_n_i),
        .sync_o(pr_n_s)
    );
    dpl_sync2 #(
        .RST_VAL(DPL_PIN_IDLE_HI)
    ) u_sync_pd (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(power_down_n_i),
        .sync_o(pd_n_s)
    );

    ////////////////////////////////////////////////////////////////////
    // next state
    logic clk_rise, cs_rise, pr_rise;
    assign clk_rise = clk_s && !st_q.clk_prev;
    assign cs_rise = cs_n_s && !st_q.cs_prev;
    assign pr_rise = pr_n_s && !st_q.pr_prev;

    always_comb begin
        st_d = st_q;
        st_d.clk_prev = clk_s;
        st_d.cs_prev = cs_n_s;
        st_d.pr_prev = pr_n_s;
        if (!pr_n_s) begin
            // preset wins over any load in the same cycle
            st_d.lat1 = DPL_MIDSCALE;
            st_d.lat2 = DPL_MIDSCALE;
            st_d.sdo_bit = 1'b0;
        end else begin
            if (clk_rise && !cs_n_s) begin
                st_d.shift_register = {st_q.shift_register[WORD_W-2:0],
                    sdi_s};
                // bit that entered eight shifts ago leaves to the chain
                st_d.sdo_bit = st_q.shift_register[DPL_CHAIN_TAP-1];
            end
            if (pr_rise && cs_n_s) begin
                st_d.lat1 = DPL_MIDSCALE;
                st_d.lat2 = DPL_MIDSCALE;
            end else if (cs_rise) begin
                // only the newest bits remain in the register
                if (CHANNELS > 1 && st_q.shift_register[WORD_W-1]) begin
                    st_d.lat2 = st_q.shift_register[DPL_CODE_W-1:0];
                end else begin
                    st_d.lat1 = st_q.shift_register[DPL_CODE_W-1:0];
                end
            end
        end
    end

    // reset stands in for the power-on preset
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= '{clk_prev: DPL_PIN_IDLE_LO, cs_prev: DPL_PIN_IDLE_HI,
                pr_prev: DPL_PIN_IDLE_HI, shift_register: '0,
                sdo_bit: 1'b0,
                lat1: DPL_MIDSCALE, lat2: DPL_MIDSCALE};
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs; latches untouched by power down
    assign wiper_code_latch1_o = st_q.lat1;
    assign wiper_code_latch2_o = st_q.lat2;
    assign high_end_open_o = !pd_n_s;
    assign wiper_to_low_o = !pd_n_s;
    assign serial_out_pin_o = 1'b0;
    // enable only while chip select low, off in power down
    assign serial_out_pin_oe_o = pd_n_s && !cs_n_s && !st_q.sdo_bit;

    ////////////////////////////////////////////////////////////////////
    // checks
    // these watch the synchronised pins, since those are what the logic
    // acts on; pin-level timing is left to the bench
    a_preset_mid: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        !pr_n_s |=> st_q.lat1 == DPL_MIDSCALE && st_q.lat2 == DPL_MIDSCALE)
        else $error("preset did not force midscale");
    a_preset_sdo: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        !pr_n_s |=> !st_q.sdo_bit)
        else $error("preset did not clear serial out latch");
    a_load_ch1: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        cs_rise && pr_n_s && !pr_rise
        && (CHANNELS == 1 || !st_q.shift_register[WORD_W-1])
        |=> st_q.lat1 == $past(st_q.shift_register[DPL_CODE_W-1:0]))
        else $error("channel one load wrong");
    a_load_ch2: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        cs_rise && pr_n_s && !pr_rise && CHANNELS > 1
        && st_q.shift_register[WORD_W-1]
        |=> st_q.lat2 == $past(st_q.shift_register[DPL_CODE_W-1:0]))
        else $error("channel two load wrong");
    a_load_ch2_hold: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        cs_rise && pr_n_s && !pr_rise && CHANNELS > 1
        && st_q.shift_register[WORD_W-1] |=> $stable(st_q.lat1))
        else $error("channel one changed on channel two load");
    a_preset_wins: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        cs_rise && !pr_n_s
        |=> st_q.lat1 == DPL_MIDSCALE && st_q.lat2 == DPL_MIDSCALE)
        else $error("load overrode preset");
    a_shift_hold: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        !clk_rise || cs_n_s |=> $stable(st_q.shift_register))
        else $error("shift without clock rise");
    a_shift_in: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        clk_rise && !cs_n_s && pr_n_s |=> st_q.shift_register[0]
        == $past(sdi_s))
        else $error("serial bit not shifted in");
    a_chain_out: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        clk_rise && !cs_n_s && pr_n_s
        |=> st_q.sdo_bit == $past(st_q.shift_register[DPL_CHAIN_TAP-1]))
        else $error("chain output wrong");
    a_pd_sdo_off: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        !pd_n_s |-> !serial_out_pin_oe_o && high_end_open_o)
        else $error("power down did not release pins");
    a_pd_keep: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        !pd_n_s && pr_n_s && !cs_rise && !pr_rise
        |=> $stable(st_q.lat1) && $stable(st_q.lat2))
        else $error("latch changed in power down");
    a_pr_rise: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        pr_rise && cs_n_s
        |=> st_q.lat1 == DPL_MIDSCALE && st_q.lat2 == DPL_MIDSCALE)
        else $error("preset edge did not latch midscale");
endmodule : dpl_serial_latch

//--- dpl_host_model.sv
// host model that drives the digipot link pins frame by frame
`timescale 1ns/100ps
module dpl_host_model
    import dpl_pkg::*;
(
    // clock
    input wire logic mclk_i,
    // link pins
    output logic link_clk_o,
    output logic chip_sel_n_o,
    output logic serial_in_o,
    input wire logic sdo_wire_i,
    // serial out level sampled before each rise after the first and at frame end
    output logic [31:0] seen_o
);
    // mclk cycles per link clock level
    localparam int unsigned HALF = DPL_LINK_NS / DPL_MCLK_NS / 2;
    initial begin
        link_clk_o = 1'b0;
        chip_sel_n_o = 1'b1;
        serial_in_o = 1'b0;
        seen_o = 32'h0;
    end
    // clock stands low between frames; data moves only while the clock is low
    task automatic send(input int n, input logic [31:0] word);
        @(negedge mclk_i);
        chip_sel_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in_o = word[i];
            repeat (HALF) @(negedge mclk_i);
            if (i < n - 1) seen_o = {seen_o[30:0], sdo_wire_i};
            link_clk_o = 1'b1;
            repeat (HALF) @(negedge mclk_i);
            link_clk_o = 1'b0;
        end
        repeat (HALF) @(negedge mclk_i);
        if (n > 0) seen_o = {seen_o[30:0], sdo_wire_i};
        chip_sel_n_o = 1'b1;
        // released data line must not keep its last value
        serial_in_o = ~serial_in_o;
        repeat (8) @(negedge mclk_i);
    endtask : send
endmodule : dpl_host_model

//--- dpl_serial_latch_tb.sv
// self-checking bench for the digipot serial latch controller
`timescale 1ns/100ps
module dpl_serial_latch_tb
    import dpl_pkg::*;
;
    logic mclk = 1'b0, rst = 1'b1, pr_n = 1'b1, pd_n = 1'b1;
    logic lclk, csn, serial_in_pin, sout, soe, heo, wtl, sdo_wire;
    logic [7:0] l1, l2, l1s;
    logic [31:0] seen;
    int miscompares = 0;
    int num_checks = 0;
    always #(DPL_MCLK_NS / 2) mclk = ~mclk;
    // open-drain line with pull-up
    assign sdo_wire = soe ? sout : 1'b1;
    dpl_serial_latch #(.CHANNELS(2)) dut (
        .mclk_i(mclk), .sys_rst_i(rst), .link_clk_i(lclk),
        .chip_sel_n_i(csn), .serial_in_pin_i(serial_in_pin),
        .serial_out_pin_o(sout), .serial_out_pin_oe_o(soe),
        .midscale_force_n_i(pr_n), .power_down_n_i(pd_n),
        .wiper_code_latch1_o(l1), .wiper_code_latch2_o(l2),
        .high_end_open_o(heo), .wiper_to_low_o(wtl)
    );
    // single-channel part on the same link
    dpl_serial_latch #(.CHANNELS(1)) dut_single (
        .mclk_i(mclk), .sys_rst_i(rst), .link_clk_i(lclk),
        .chip_sel_n_i(csn), .serial_in_pin_i(serial_in_pin),
        .serial_out_pin_o(), .serial_out_pin_oe_o(),
        .midscale_force_n_i(pr_n), .power_down_n_i(pd_n),
        .wiper_code_latch1_o(l1s), .wiper_code_latch2_o(),
        .high_end_open_o(), .wiper_to_low_o()
    );
    dpl_host_model host (
        .mclk_i(mclk), .link_clk_o(lclk), .chip_sel_n_o(csn),
        .serial_in_o(serial_in_pin), .sdo_wire_i(sdo_wire), .seen_o(seen)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    task automatic hold(input int n);
        repeat (n) @(negedge mclk);
    endtask : hold
    initial begin
        #1000000;
        miscompares++;
        give_verdict();
    end
    initial begin
        hold(8);
        rst = 1'b0;
        hold(4);
        chk(l1, DPL_MIDSCALE);
        chk(l2, DPL_MIDSCALE);
        chk(l1s, DPL_MIDSCALE);
        $display("test power-on done");
        host.send(9, 32'h0a5);
        chk(l1, 8'ha5);
        chk(l2, DPL_MIDSCALE);
        chk(l1s, 8'ha5);
        // two surplus bits lead the word
        host.send(11, 32'h53c);
        chk(l2, 8'h3c);
        chk(l1, 8'ha5);
        chk(l1s, 8'h3c);
        host.send(18, {9'h15a, 9'h0c3});
        chk(l1, 8'hc3);
        chk(seen[9:0], 10'h2b4);
        chk(sout, 1'b0);
        chk(soe, 1'b0);
        $display("test channel load and chain done");
        pr_n = 1'b0;
        hold(4);
        chk(l1, DPL_MIDSCALE);
        host.send(9, 32'h011);
        chk(l1, DPL_MIDSCALE);
        pr_n = 1'b1;
        hold(6);
        chk(l1, DPL_MIDSCALE);
        $display("test preset done");
        host.send(9, 32'h077);
        pd_n = 1'b0;
        hold(4);
        chk({heo, wtl}, 2'b11);
        host.send(9, 32'h100);
        chk(seen[8:0], 9'h1ff);
        chk(l1, 8'h77);
        pd_n = 1'b1;
        hold(4);
        chk({heo, wtl}, 2'b00);
        $display("test power down done");
        give_verdict();
    end
endmodule : dpl_serial_latch_tb
